/* pkg/icu_pkg.sv */
// shared constants for the input capture unit
package icu_pkg;
    // register byte offsets on apb
    localparam logic [11:0] ICU_OFF_CONTROL = 12'h000; // module_control
    localparam logic [11:0] ICU_OFF_CAP_LOW = 12'h004; // capture_value_low
    localparam logic [11:0] ICU_OFF_CAP_HIGH = 12'h008; // capture_value_high
    localparam logic [11:0] ICU_OFF_IRQ = 12'h00C; // flag and enable
    localparam logic [11:0] ICU_OFF_TIMER = 12'h010; // companion timer control
    localparam logic [11:0] ICU_OFF_PORT = 12'h014; // pin direction, latch, location
    // capture mode codes in module_control[3:0]
    localparam logic [3:0] ICU_MODE_OFF = 4'h0;
    localparam logic [3:0] ICU_MODE_FALL = 4'h4;
    localparam logic [3:0] ICU_MODE_RISE = 4'h5;
    localparam logic [3:0] ICU_MODE_RISE4 = 4'h6;
    localparam logic [3:0] ICU_MODE_RISE16 = 4'h7;
    // field positions
    localparam int ICU_MODE_LSB = 0;
    localparam int ICU_MODE_MSB = 3;
    localparam int ICU_IRQ_FLAG_BIT = 0;
    localparam int ICU_IRQ_EN_BIT = 1;
    localparam int ICU_TMR_ON_BIT = 0;
    localparam int ICU_TMR_EXT_BIT = 1;
    localparam int ICU_PORT_DIR_BIT = 0;
    localparam int ICU_PORT_LAT_BIT = 1;
    localparam int ICU_PORT_SEL_BIT = 2;
    // reset values
    localparam logic [7:0] ICU_CONTROL_RST = 8'h00;
    localparam logic [15:0] ICU_CAPTURE_RST = 16'h0000;
    localparam logic [2:0] ICU_PORT_RST = 3'h1;
    // prescale terminal counts (count of qualifying edges minus one)
    localparam logic [3:0] ICU_PS_DIV1 = 4'h0;
    localparam logic [3:0] ICU_PS_DIV4 = 4'h3;
    localparam logic [3:0] ICU_PS_DIV16 = 4'hF;
    localparam logic [31:0] ICU_READ_ZERO = 32'h00000000;
endpackage : icu_pkg

/* verilog/icu_sync.sv */
`timescale 1ns/1ps
`default_nettype none
// two-flop level synchroniser for the capture pin
module icu_sync (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic din,
    output logic dout
);
    logic meta; // first stage, read only by the second
    // only dout may be observed downstream
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta <= 1'b0;
            dout <= 1'b0;
        end else if (clk_en) begin
            meta <= din;
            dout <= meta;
        end
    end
endmodule : icu_sync
`default_nettype wire

/* verilog/icu_edge_prescaler.sv */
`timescale 1ns/1ps
`default_nettype none
// edge selection and prescale counting
module icu_edge_prescaler
    import icu_pkg::*;
#(
    parameter int PS_WIDTH = 4
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic pin_sync,
    input wire logic [3:0] mode,
    output logic capture_event
);
    logic pin_prev; // last synchronised level
    logic [PS_WIDTH-1:0] ps_count; // qualifying edges seen
    logic rise; // rising edge seen this cycle
    logic fall; // falling edge seen this cycle
    logic qualify; // edge matches mode
    logic [PS_WIDTH-1:0] terminal; // count at which capture fires
    logic capture_mode; // mode is one of the capture codes

    assign rise = pin_sync & ~pin_prev;
    assign fall = ~pin_sync & pin_prev;

    // decode mode into edge kind and terminal count
    always_comb begin
        capture_mode = 1'b1;
        qualify = 1'b0;
        terminal = PS_WIDTH'(ICU_PS_DIV1);
        unique case (mode)
            ICU_MODE_FALL: qualify = fall; // [RULE2]
            ICU_MODE_RISE: qualify = rise; // [RULE2]
            ICU_MODE_RISE4: begin
                qualify = rise; // [RULE2]
                terminal = PS_WIDTH'(ICU_PS_DIV4);
            end
            ICU_MODE_RISE16: begin
                qualify = rise; // [RULE2]
                terminal = PS_WIDTH'(ICU_PS_DIV16);
            end
            default: capture_mode = 1'b0; // off, compare or pwm codes
        endcase
    end

    // previous level tracks the pin even when off, so a mode change can
    // see an edge at once; that is the known false-capture hazard
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_prev <= 1'b0;
        end else if (clk_en) begin
            pin_prev <= pin_sync;
        end
    end

    // prescale counter: cleared by reset and whenever not capturing,
    // kept across a change between prescale settings
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ps_count <= '0; // [RULE11]
        end else if (clk_en) begin
            if (!capture_mode) begin
                ps_count <= '0; // [RULE10]
            end else if (qualify) begin
                if (ps_count >= terminal) begin
                    ps_count <= '0; // [RULE20]
                end else begin
                    ps_count <= ps_count + 1'b1;
                end
            end
        end
    end

    // fires on the edge that completes the count; a stale count above the
    // new terminal fires at once after a prescale switch [RULE12] [RULE8]
    assign capture_event = capture_mode & qualify & (ps_count >= terminal); // [RULE20]
endmodule : icu_edge_prescaler
`default_nettype wire

/* verilog/icu_top.sv */
// The APB register port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
// Function
// [RULE1] copy full timer count into capture pair
// [RULE2] mode picks falling, rising, 4th, 16th rise
// [RULE3] set flag on every capture
// [RULE4] software clears flag, hardware never does
// [RULE5] newer capture overwrites unread value
// [RULE6] output port writes can trigger capture
// [RULE7] timer must be synchronous for captures
// [RULE8] mode change may cause false capture
// [RULE9] software masks enable, clears flag after change
// [RULE10] prescaler cleared when off or not capturing
// [RULE11] any reset clears prescaler
// [RULE12] prescale switch keeps count, may false-capture
// [RULE13] software zeroes control before new prescale
// [RULE14] timer clock is instruction or external
// [RULE15] instruction-clocked timer holds count in sleep
// [RULE16] external-clocked capture keeps working in sleep
// [RULE17] software sets pin as input
// [RULE18] select bit moves capture pin location
// [RULE19] synchronise input, write both bytes together
// [RULE20] capture on completing edge, counter restarts
module icu_top
    import icu_pkg::*;
#(
    parameter int TIMER_WIDTH = 16,
    parameter int PS_WIDTH = 4
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic capture_pin_a_in,
    output logic capture_pin_a_out,
    output logic capture_pin_a_oe,
    input wire logic capture_pin_b_in,
    output logic capture_pin_b_out,
    output logic capture_pin_b_oe,
    input wire logic ext_timer_tick,
    input wire logic sleep_mode,
    output logic capture_irq
);
    logic [7:0] module_control; // mode in low nibble
    logic [TIMER_WIDTH-1:0] capture_value; // high and low byte pair
    logic capture_irq_flag; // sticky capture flag
    logic capture_irq_enable; // flag gate onto irq
    logic timer_on; // companion timer run bit
    logic timer_ext; // 1 = external tick source
    logic [TIMER_WIDTH-1:0] timer_count; // companion timer
    logic pin_direction_bit; // 1 = pin is input
    logic pin_latch; // port output latch
    logic capture_pin_location_select; // 0 = pin a, 1 = pin b
    logic pin_raw; // selected pin level
    logic pin_sync; // synchronised level
    logic capture_event; // qualifying event, one cycle
    logic timer_tick; // timer advances this cycle
    logic wr_en; // apb write access phase
    logic addr_ok; // address is mapped
    logic flag_clear; // software clears flag
    logic [31:0] next_prdata; // read mux

    // both pads follow one latch; only the selected pad gets its enable
    // the pad reads back the driven latch when it is an output, so
    // writing the latch looks like an input edge [RULE6]
    always_comb begin
        capture_pin_a_out = pin_latch;
        capture_pin_b_out = pin_latch;
        capture_pin_a_oe = ~pin_direction_bit & ~capture_pin_location_select;
        capture_pin_b_oe = ~pin_direction_bit & capture_pin_location_select;
        if (capture_pin_location_select) begin
            pin_raw = pin_direction_bit ? capture_pin_b_in : pin_latch; // [RULE18] [RULE6]
        end else begin
            pin_raw = pin_direction_bit ? capture_pin_a_in : pin_latch; // [RULE18] [RULE6]
        end
    end

    // external pin is asynchronous to pclk
    icu_sync u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .clk_en(clk_en),
        .din(pin_raw),
        .dout(pin_sync) // [RULE19]
    );

    // edge detector and prescaler
    icu_edge_prescaler #(
        .PS_WIDTH(PS_WIDTH)
    ) u_presc (
        .pclk(pclk),
        .presetn(presetn),
        .clk_en(clk_en),
        .pin_sync(pin_sync),
        .mode(module_control[ICU_MODE_MSB:ICU_MODE_LSB]),
        .capture_event(capture_event)
    );

    // apb: zero wait states, every access completes in its first access cycle
    assign pready = 1'b1;
    // a write lands at the access edge; the setup cycle only loads read data
    // clk_en low drops the write, yet pready stays high so no master hangs
    assign wr_en = psel & penable & pwrite;
    assign addr_ok = (paddr == ICU_OFF_CONTROL) || (paddr == ICU_OFF_CAP_LOW) ||
                     (paddr == ICU_OFF_CAP_HIGH) || (paddr == ICU_OFF_IRQ) ||
                     (paddr == ICU_OFF_TIMER) || (paddr == ICU_OFF_PORT);
    assign pslverr = psel & penable & ~addr_ok; // unmapped answers error
    assign flag_clear = wr_en && (paddr == ICU_OFF_IRQ) && pstrb[0] &&
                        !pwdata[ICU_IRQ_FLAG_BIT];

    // instruction-clocked timer stops in sleep, external keeps counting
    assign timer_tick = timer_on & (timer_ext ? ext_timer_tick : ~sleep_mode); // [RULE15] [RULE16]

    // module control register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            module_control <= ICU_CONTROL_RST;
        end else if (clk_en) begin
            if (wr_en && paddr == ICU_OFF_CONTROL && pstrb[0]) begin
                module_control <= pwdata[7:0];
            end
        end
    end

    // companion timer, holds its count while not ticking
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_count <= '0;
        end else if (clk_en) begin
            // a load wins over a tick, so software reads back what it wrote
            if (wr_en && paddr == ICU_OFF_TIMER && pstrb[2]) begin
                timer_count[7:0] <= pwdata[23:16];
                timer_count[TIMER_WIDTH-1:8] <= pwdata[31:24];
            end else if (timer_tick) begin
                timer_count <= timer_count + 1'b1; // [RULE15]
            end
        end
    end

    // timer control bits
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_on <= 1'b0;
            timer_ext <= 1'b0;
        end else if (clk_en) begin
            if (wr_en && paddr == ICU_OFF_TIMER && pstrb[0]) begin
                timer_on <= pwdata[ICU_TMR_ON_BIT];
                timer_ext <= pwdata[ICU_TMR_EXT_BIT];
            end
        end
    end

    // capture pair: both bytes on one edge so the stored pair never mixes two captures; a capture
    // beats a software write in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            capture_value <= ICU_CAPTURE_RST;
        end else if (clk_en) begin
            // no guard for an unread value: the newest capture always lands
            if (capture_event) begin
                capture_value <= timer_count; // [RULE1] [RULE5] [RULE19]
            end else if (wr_en && pstrb[0]) begin
                if (paddr == ICU_OFF_CAP_LOW) begin
                    capture_value[7:0] <= pwdata[7:0];
                end
                if (paddr == ICU_OFF_CAP_HIGH) begin
                    capture_value[TIMER_WIDTH-1:8] <= pwdata[7:0];
                end
            end
        end
    end

    // sticky flag: set wins over a clear in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            capture_irq_flag <= 1'b0;
        end else if (clk_en) begin
            // hardware only ever sets; the one clear path is a software write
            if (capture_event) begin
                capture_irq_flag <= 1'b1; // [RULE3] [RULE8]
            end else if (flag_clear) begin
                capture_irq_flag <= 1'b0; // [RULE4]
            end
        end
    end

    // interrupt enable bit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            capture_irq_enable <= 1'b0;
        end else if (clk_en) begin
            if (wr_en && paddr == ICU_OFF_IRQ && pstrb[0]) begin
                capture_irq_enable <= pwdata[ICU_IRQ_EN_BIT];
            end
        end
    end

    // port direction, latch and location select
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_direction_bit <= ICU_PORT_RST[ICU_PORT_DIR_BIT];
            pin_latch <= ICU_PORT_RST[ICU_PORT_LAT_BIT];
            capture_pin_location_select <= ICU_PORT_RST[ICU_PORT_SEL_BIT];
        end else if (clk_en) begin
            if (wr_en && paddr == ICU_OFF_PORT && pstrb[0]) begin
                pin_direction_bit <= pwdata[ICU_PORT_DIR_BIT];
                pin_latch <= pwdata[ICU_PORT_LAT_BIT];
                capture_pin_location_select <= pwdata[ICU_PORT_SEL_BIT]; // [RULE18]
            end
        end
    end

    // interrupt output, registered
    // one cycle behind the flag, which keeps the output free of glitches
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            capture_irq <= 1'b0;
        end else if (clk_en) begin
            capture_irq <= capture_irq_flag & capture_irq_enable;
        end
    end

    // read mux, unused bits zero
    // the pair is not latched across two byte reads: a capture landing
    // between the low and the high read gives bytes of two captures
    always_comb begin
        next_prdata = ICU_READ_ZERO;
        unique case (paddr)
            ICU_OFF_CONTROL: next_prdata[7:0] = module_control;
            ICU_OFF_CAP_LOW: next_prdata[7:0] = capture_value[7:0];
            ICU_OFF_CAP_HIGH: next_prdata[7:0] = capture_value[TIMER_WIDTH-1:8];
            ICU_OFF_IRQ: begin
                next_prdata[ICU_IRQ_FLAG_BIT] = capture_irq_flag;
                next_prdata[ICU_IRQ_EN_BIT] = capture_irq_enable;
            end
            ICU_OFF_TIMER: begin
                next_prdata[ICU_TMR_ON_BIT] = timer_on;
                next_prdata[ICU_TMR_EXT_BIT] = timer_ext;
                next_prdata[31:16] = timer_count;
            end
            ICU_OFF_PORT: begin
                next_prdata[ICU_PORT_DIR_BIT] = pin_direction_bit;
                next_prdata[ICU_PORT_LAT_BIT] = pin_latch;
                next_prdata[ICU_PORT_SEL_BIT] = capture_pin_location_select;
            end
            default: next_prdata = ICU_READ_ZERO; // unmapped reads zero
        endcase
    end

    // read data registered in the setup cycle so it stands in access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= ICU_READ_ZERO;
        end else if (clk_en) begin
            if (psel && !penable && !pwrite) begin
                prdata <= next_prdata;
            end
        end
    end
endmodule : icu_top
`default_nettype wire

/* tb/icu_top_properties.sv */
`timescale 1ns/1ps
`default_nettype none
// port-level checks for the capture unit
module icu_top_properties
    import icu_pkg::*;
#(
    parameter int TIMER_WIDTH = 16,
    parameter int PS_WIDTH = 4
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic capture_pin_a_out,
    input wire logic capture_pin_a_oe,
    input wire logic capture_pin_b_out,
    input wire logic capture_pin_b_oe,
    input wire logic capture_irq
);
    logic acc; // access phase
    logic mapped; // address hits a register
    logic irq_wr; // accepted write to flag/enable
    logic port_wr; // accepted write to pin control
    logic [2:0] port_val; // shadow of pin control bits
    assign acc = psel && penable;
    assign mapped = paddr inside {ICU_OFF_CONTROL, ICU_OFF_CAP_LOW, ICU_OFF_CAP_HIGH,
        ICU_OFF_IRQ, ICU_OFF_TIMER, ICU_OFF_PORT};
    assign irq_wr = acc && pwrite && clk_en && pstrb[0] && (paddr == ICU_OFF_IRQ);
    assign port_wr = acc && pwrite && clk_en && pstrb[0] && (paddr == ICU_OFF_PORT);
    // shadow tracks pin control so pin enables can be checked every cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_val <= ICU_PORT_RST;
        end else if (port_wr) begin
            port_val <= pwdata[2:0];
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_ready_always: assert property (pready) else $error("pready low");
    a_slverr_decode: assert property (acc |-> pslverr == !mapped) else $error("bad pslverr");
    a_unmapped_zero: assert property (acc && !pwrite && !mapped |-> prdata == ICU_READ_ZERO)
        else $error("unmapped read not zero");
    a_flag_stays_set: assert property (
        capture_irq && !irq_wr && !$past(irq_wr) |=> capture_irq)
        else $error("irq dropped without software clear");
    a_mask_drops_irq: assert property (
        irq_wr && !pwdata[ICU_IRQ_EN_BIT] ##1 clk_en |=> !capture_irq)
        else $error("irq high while disabled");
    a_oe_pin_a: assert property (capture_pin_a_oe == (!port_val[0] && !port_val[2]))
        else $error("pin a enable wrong");
    a_oe_pin_b: assert property (capture_pin_b_oe == (!port_val[0] && port_val[2]))
        else $error("pin b enable wrong");
    a_out_latch: assert property (
        capture_pin_a_out == port_val[1] && capture_pin_b_out == port_val[1])
        else $error("pin output not latch");
endmodule : icu_top_properties
bind icu_top icu_top_properties #(.TIMER_WIDTH(TIMER_WIDTH), .PS_WIDTH(PS_WIDTH)) u_props (
    .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .capture_pin_a_out(capture_pin_a_out),
    .capture_pin_a_oe(capture_pin_a_oe), .capture_pin_b_out(capture_pin_b_out),
    .capture_pin_b_oe(capture_pin_b_oe), .capture_irq(capture_irq));
`default_nettype wire

/* tb/icu_pin_model.sv */
`timescale 1ns/1ps
`default_nettype none
// external event source at both pin locations
module icu_pin_model (
    input wire logic pclk,
    output logic pin_a,
    output logic pin_b
);
    // one high pulse, each level held past the two-flop synchroniser
    task automatic pulse(input logic loc);
        repeat (2) begin
            @(posedge pclk);
            if (loc) pin_b <= ~pin_b;
            else pin_a <= ~pin_a;
            repeat (5) @(posedge pclk);
        end
    endtask : pulse
    // both lines idle low between events
    initial begin
        pin_a = 1'b0;
        pin_b = 1'b0;
    end
endmodule : icu_pin_model
`default_nettype wire

/* tb/tb.sv */
`timescale 1ns/1ps
`default_nettype none
// register-level bench for the capture unit
module tb
    import icu_pkg::*;
;
    logic pclk;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, tick = 1'b0, sleep = 1'b0, en = 1'b1;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [3:0] pstrb = 4'hF; // timer count load needs lane 2, the other registers lane 0
    logic [31:0] prdata, rd;
    logic pready, pslverr, err, irq, a_out, a_oe, b_out, b_oe, m_a, m_b;
    logic [3:0] modes [4] = '{ICU_MODE_FALL, ICU_MODE_RISE, ICU_MODE_RISE4, ICU_MODE_RISE16};
    int counts [4] = '{1, 1, 4, 16};
    int n_errors = 0;
    int checked = 0;
    // wire level: the unit's own driver wins while enabled
    wire logic pin_a = a_oe ? a_out : m_a;
    wire logic pin_b = b_oe ? b_out : m_b;
    icu_top #(.TIMER_WIDTH(16), .PS_WIDTH(4)) dut (
        .pclk(pclk), .presetn(presetn), .clk_en(en), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .capture_pin_a_in(pin_a),
        .capture_pin_a_out(a_out), .capture_pin_a_oe(a_oe), .capture_pin_b_in(pin_b),
        .capture_pin_b_out(b_out), .capture_pin_b_oe(b_oe), .ext_timer_tick(tick),
        .sleep_mode(sleep), .capture_irq(irq));
    icu_pin_model pin (.pclk(pclk), .pin_a(m_a), .pin_b(m_b));
    // 125 mhz clock
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    // hang guard, far beyond the little over a thousand cycles needed
    initial begin
        #160000;
        n_errors++;
        give_verdict();
    end
    task automatic give_verdict();
        if (n_errors == 0 && checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : give_verdict
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask : cyc
    task automatic reset_dut();
        presetn <= 1'b0;
        cyc(3);
        presetn <= 1'b1;
    endtask : reset_dut
    // one apb transfer; held until pready is seen with the access phase
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
    task automatic rdc(input string what, input logic [11:0] a, input logic [31:0] exp,
            input logic [31:0] m);
        xfer(1'b0, a, 32'h00000000);
        check(what, rd & m, exp);
    endtask : rdc
    // flag bit and the interrupt line together
    task automatic flag(input logic e);
        rdc("flag", ICU_OFF_IRQ, {31'h0, e}, 32'h00000001);
        check("irq", {31'h0, irq}, {31'h0, e});
    endtask : flag
    task automatic pulses(input logic loc, input int n);
        repeat (n) pin.pulse(loc);
    endtask : pulses
    task automatic cap(input logic [15:0] v);
        rdc("cap low", ICU_OFF_CAP_LOW, {24'h0, v[7:0]}, 32'h000000FF);
        rdc("cap high", ICU_OFF_CAP_HIGH, {24'h0, v[15:8]}, 32'h000000FF);
    endtask : cap
    // module off, new mode, frozen external-source timer, then clean flag
    task automatic setup(input logic [3:0] mode, input logic [15:0] v);
        xfer(1'b1, ICU_OFF_IRQ, 32'h00000000);
        xfer(1'b1, ICU_OFF_CONTROL, 32'h00000000);
        xfer(1'b1, ICU_OFF_CONTROL, {28'h0, mode});
        xfer(1'b1, ICU_OFF_TIMER, {v, 16'h0003});
        xfer(1'b1, ICU_OFF_IRQ, 32'h00000002);
    endtask : setup
    initial begin
        reset_dut();
        rdc("control", ICU_OFF_CONTROL, 32'h0, 32'h000000FF);
        cap(ICU_CAPTURE_RST);
        rdc("irq reg", ICU_OFF_IRQ, 32'h0, 32'h00000003);
        rdc("port", ICU_OFF_PORT, {29'h0, ICU_PORT_RST}, 32'h00000007);
        xfer(1'b0, 12'h018, 32'h0);
        check("slverr", {31'h0, err}, 32'h1);
        check("unmapped", rd, ICU_READ_ZERO);
        // clock enable low: the write is lost
        en <= 1'b0;
        xfer(1'b1, ICU_OFF_CONTROL, {28'h0, ICU_MODE_RISE});
        en <= 1'b1;
        rdc("frozen", ICU_OFF_CONTROL, 32'h0, 32'h000000FF);
        // each mode: capture on the completing edge, restart, overwrite
        for (int i = 0; i < 4; i++) begin
            setup(modes[i], 16'hA5C3);
            pulses(1'b0, counts[i] - 1);
            flag(1'b0);
            pulses(1'b0, 1);
            flag(1'b1);
            pulses(1'b0, counts[i] - 1);
            xfer(1'b1, ICU_OFF_TIMER, {16'h3C5A, 16'h0003});
            pulses(1'b0, 1);
            cap(16'h3C5A);
            flag(1'b1);
        end
        // partial count lost by module off, then by reset
        for (int k = 0; k < 2; k++) begin
            setup(ICU_MODE_RISE4, 16'hA5C3);
            pulses(1'b0, 2);
            if (k == 1) reset_dut();
            setup(ICU_MODE_RISE4, 16'hA5C3);
            pulses(1'b0, 3);
            flag(1'b0);
            pulses(1'b0, 1);
            flag(1'b1);
        end
        // direct prescale switch keeps the count
        setup(ICU_MODE_RISE16, 16'hA5C3);
        pulses(1'b0, 5);
        xfer(1'b1, ICU_OFF_CONTROL, {28'h0, ICU_MODE_RISE4});
        xfer(1'b1, ICU_OFF_IRQ, 32'h00000002);
        pulses(1'b0, 1);
        flag(1'b1);
        // output mode: latch write makes the edge
        setup(ICU_MODE_RISE, 16'hA5C3);
        xfer(1'b1, ICU_OFF_PORT, 32'h00000000);
        xfer(1'b1, ICU_OFF_IRQ, 32'h00000002);
        xfer(1'b1, ICU_OFF_PORT, 32'h00000002);
        cyc(6);
        flag(1'b1);
        // alternate location: only pin b counts
        setup(ICU_MODE_RISE, 16'hA5C3);
        xfer(1'b1, ICU_OFF_PORT, 32'h00000005);
        xfer(1'b1, ICU_OFF_IRQ, 32'h00000002);
        pulses(1'b0, 1);
        flag(1'b0);
        pulses(1'b1, 1);
        flag(1'b1);
        xfer(1'b1, ICU_OFF_PORT, 32'h00000001);
        // sleep: external ticks still count and capture
        sleep <= 1'b1;
        setup(ICU_MODE_RISE, 16'hA5C3);
        tick <= 1'b1;
        cyc(5);
        tick <= 1'b0;
        pulses(1'b0, 1);
        cap(16'hA5C8);
        // sleep: instruction-clocked timer holds, then resumes
        xfer(1'b1, ICU_OFF_TIMER, {16'hA5C3, 16'h0001});
        cyc(10);
        rdc("timer held", ICU_OFF_TIMER, {16'hA5C3, 16'h0}, 32'hFFFF0000);
        sleep <= 1'b0;
        cyc(10);
        // eleven ticks from the held count before the read setup edge
        rdc("timer runs", ICU_OFF_TIMER, {16'hA5CE, 16'h0}, 32'hFFFF0000);
        give_verdict();
    end
endmodule : tb
`default_nettype wire
